// file: hdl/seq_defines.svh
// Purpose: command codes, field positions, reset values and timing counts
// Assumes: quarter millisecond is the common time unit of the sequencer
// Notes:   definitions only
`ifndef SEQ_DEFINES_SVH
`define SEQ_DEFINES_SVH

`define CMD_POLICY        8'h63
`define CMD_OFF_DELAY     8'h64
`define CMD_FALL_TIME     8'h65
`define EXP_MSB           15
`define EXP_LSB           11
`define MAN_MSB           10
`define RESP_MSB          7
`define RESP_LSB          6
`define RETRY_MSB         5
`define RETRY_LSB         3
`define DELAY_MSB         2
`define OFF_DELAY_EXP_RST 5'h1F
`define FALL_EXP_RST      5'h1E
`define POLICY_RST        8'h80
`define OFF_DELAY_MAN_RST 11'h000
`define FALL_MAN_RST      11'h004
`define OFF_DELAY_MAX_Q   16'h01FE
`define FALL_MAX_Q        16'h007F
`define FALL_MIN_Q        16'h0002
`define TICKS_PER_MS      3'h4
`define RETRY_FOREVER     3'h7
`define REF_FULL          10'h3FF
`define CLOCK_NS          20
`define TICK_NS           250000
`define TICK_CYCLES       (`TICK_NS / `CLOCK_NS)

`endif

// file: hdl/seq_pkg.sv
// Purpose: types shared by the sequencer files
// Assumes: nothing
// Notes:   numbers live in seq_defines.svh
package seq_pkg;
	typedef enum logic [1:0] {
		RESP_IGNORE    = 2'h0,
		RESP_DELAYED   = 2'h1,
		RESP_IMMEDIATE = 2'h2,
		RESP_INVALID   = 2'h3
	} resp_t;
	// gray along off, ramp, on, off delay, fall
	typedef enum logic [2:0] {
		ST_OFF       = 3'h0,
		ST_RAMP      = 3'h1,
		ST_ON        = 3'h3,
		ST_OFF_DELAY = 3'h2,
		ST_FALL      = 3'h6,
		ST_HICCUP    = 3'h7,
		ST_FAULT_DLY = 3'h5,
		ST_LATCHED   = 3'h4
	} state_t;
	typedef struct packed {
		resp_t      timeout_response_select;
		logic [2:0] timeout_retry_count;
		logic [2:0] timeout_delay_multiplier;
	} policy_t;
	typedef struct packed {
		logic        write;
		logic        word;
		logic [7:0]  code;
		logic [15:0] data;
	} cmd_t;
	typedef struct packed {
		logic        ok;
		logic [15:0] q;
	} quarter_t;
endpackage : seq_pkg

// file: hdl/startup_fault_and_soft_off_control.sv
// Purpose: start-up timeout fault policy and soft-off sequencing
// Assumes: command port already decoded from the bus; inputs synchronous
// Notes:   times counted in quarter ms ticks, fall ramp per clock cycle
`timescale 1ns/100ps
`include "seq_defines.svh"
module startup_fault_and_soft_off_control #(
	parameter int         TICK_CYCLES   = `TICK_CYCLES,
	parameter logic [7:0] POLICY_NVM    = `POLICY_RST,
	parameter logic [10:0] OFF_MAN_NVM  = `OFF_DELAY_MAN_RST,
	parameter logic [10:0] FALL_MAN_NVM = `FALL_MAN_RST
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// command port
	input  wire logic             cmd_valid,
	input  wire seq_pkg::cmd_t    cmd,
	output logic                  rsp_valid,
	output logic [15:0]           rsp_data,
	// on/off and telemetry
	input  wire logic             run_request,
	input  wire logic             ton_max_expire,
	input  wire logic             in_regulation_band,
	input  wire logic [15:0]      vout_sample,
	input  wire logic [15:0]      vout_target,
	input  wire logic             clear_faults,
	// status
	output logic                  status_none_of_above,
	output logic                  status_word_vout,
	output logic                  status_vout_ton_max,
	output logic                  status_cml_invalid_data,
	output logic                  status_cml_invalid_cmd,
	output logic                  alert_n,
	// power stage
	output logic                  power_enable,
	output logic [9:0]            ref_level,
	output seq_pkg::state_t       seq_state,
	output logic [2:0]            restart_attempts
);
	seq_pkg::policy_t policy;
	logic [15:0]      off_word;
	logic [15:0]      fall_word;
	seq_pkg::state_t  prev_state;
	logic [19:0]      phase_ticks;
	logic [15:0]      rise_time;
	logic [31:0]      fall_acc;
	logic             tick;

	// refuse settings that the single step ramp or the policy decode cannot serve
	if (TICK_CYCLES < 512)
	begin : g_tick_check
		$error("tick too short for single step fall ramp");
	end
	if (POLICY_NVM[`RESP_MSB:`RESP_LSB] == seq_pkg::RESP_INVALID)
	begin : g_policy_check
		$error("policy default holds an invalid response");
	end

	// linear11 word to quarter ms units, with range check
	function automatic seq_pkg::quarter_t to_quarter(input logic [15:0] w,
		input logic [15:0] max_q);
		seq_pkg::quarter_t r;
		int m;
		int e;
		int q;
		m = int'($signed(w[`MAN_MSB:0]));
		e = int'($signed(w[`EXP_MSB:`EXP_LSB])) + 2;
		q = 0;
		r.ok = 1'b1;
		if (m < 0)
			r.ok = 1'b0;
		else if (e > 16)
			r.ok = (m == 0);
		else if (e >= 0)
			q = m << e;
		else
		begin
			if ((m % (1 << (-e))) != 0)
				r.ok = 1'b0;
			q = m >> (-e);
		end
		if (q > int'(max_q))
			r.ok = 1'b0;
		r.q = r.ok ? 16'(q) : 16'h0000;
		return r;
	endfunction : to_quarter

	// 87.5% compare: 8 x sample against 7 x target
	function automatic logic below_band(input logic [15:0] s, input logic [15:0] t);
		return ({3'h0, s} << 3) < (19'(t) * 19'd7);
	endfunction : below_band

	// command decode
	seq_pkg::quarter_t off_wr;
	seq_pkg::quarter_t fall_wr;
	seq_pkg::quarter_t off_now;
	seq_pkg::quarter_t fall_now;
	logic wr_policy;
	logic wr_off;
	logic wr_fall;
	logic known_cmd;
	logic bad_data;
	assign off_wr    = to_quarter(cmd.data, `OFF_DELAY_MAX_Q);
	assign fall_wr   = to_quarter(cmd.data, `FALL_MAX_Q);
	assign off_now   = to_quarter(off_word, `OFF_DELAY_MAX_Q);
	assign fall_now  = to_quarter(fall_word, `FALL_MAX_Q);
	assign known_cmd = (cmd.code == `CMD_POLICY && !cmd.word)
		|| ((cmd.code == `CMD_OFF_DELAY || cmd.code == `CMD_FALL_TIME) && cmd.word);
	assign wr_policy = cmd_valid && cmd.write && known_cmd && cmd.code == `CMD_POLICY;
	assign wr_off    = cmd_valid && cmd.write && known_cmd && cmd.code == `CMD_OFF_DELAY;
	assign wr_fall   = cmd_valid && cmd.write && known_cmd && cmd.code == `CMD_FALL_TIME;
	assign bad_data  = (wr_policy && cmd.data[`RESP_MSB:`RESP_LSB] == seq_pkg::RESP_INVALID)
		|| (wr_off && !off_wr.ok)
		|| (wr_fall && !fall_wr.ok);

	// settings; rejected writes leave the old value in place
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			policy    <= POLICY_NVM;
			off_word  <= {`OFF_DELAY_EXP_RST, OFF_MAN_NVM};
			fall_word <= {`FALL_EXP_RST, FALL_MAN_NVM};
		end
		else
		begin
			if (wr_policy && !bad_data)
				policy <= cmd.data[7:0];
			if (wr_off && !bad_data)
				off_word <= cmd.data;
			if (wr_fall && !bad_data)
				fall_word <= cmd.data;
		end
	end

	// read answer, one cycle after the request
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rsp_valid <= 1'b0;
			rsp_data  <= 16'h0000;
		end
		else
		begin
			rsp_valid <= cmd_valid && !cmd.write && known_cmd;
			case (cmd.code)
				`CMD_POLICY:    rsp_data <= {8'h00, policy};
				`CMD_OFF_DELAY: rsp_data <= off_word;
				`CMD_FALL_TIME: rsp_data <= fall_word;
				default:        rsp_data <= 16'h0000;
			endcase
		end
	end

	// fault detection and derived timing
	logic        fault_event;
	logic        running;
	logic [15:0] fall_q;
	logic [31:0] fall_cycles;
	logic [2:0]  mult;
	logic [18:0] hiccup_ticks;
	logic        phase_restart;
	logic        delay_done;
	logic        go_shut;
	logic        to_hiccup;
	seq_pkg::resp_t resp;
	logic [2:0]  retry;
	assign resp        = policy.timeout_response_select;
	assign retry       = policy.timeout_retry_count;
	assign running     = seq_state == seq_pkg::ST_RAMP || seq_state == seq_pkg::ST_ON;
	assign fault_event = running && ton_max_expire
		&& below_band(vout_sample, vout_target);
	// short fall settings run at the minimum
	assign fall_q      = (fall_now.q < `FALL_MIN_Q) ? `FALL_MIN_Q : fall_now.q;
	assign fall_cycles = 32'(fall_q) * 32'(TICK_CYCLES);
	assign mult        = (policy.timeout_delay_multiplier == 3'h0) ? 3'h1
		: policy.timeout_delay_multiplier;
	assign hiccup_ticks  = 19'(rise_time) * 19'(mult);
	assign phase_restart = seq_state != prev_state;
	assign delay_done    = !phase_restart
		&& phase_ticks >= 20'(policy.timeout_delay_multiplier) * 20'(`TICKS_PER_MS);
	assign go_shut = (fault_event && resp == seq_pkg::RESP_IMMEDIATE)
		|| (seq_state == seq_pkg::ST_FAULT_DLY && delay_done
		&& below_band(vout_sample, vout_target));
	assign to_hiccup = retry == `RETRY_FOREVER
		|| (retry != 3'h0 && restart_attempts < retry);

	tick_divider #(
		.CYCLES (TICK_CYCLES)
	) u_tick (
		.clock   (clock),
		.rst_n   (rst_n),
		.restart (phase_restart),
		.tick    (tick)
	);

	// phase timer, restarted on every state change
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			prev_state  <= seq_pkg::ST_OFF;
			phase_ticks <= 20'h00000;
		end
		else
		begin
			prev_state <= seq_state;
			if (phase_restart)
				phase_ticks <= 20'h00000;
			else if (tick && phase_ticks != 20'hFFFFF)
				phase_ticks <= phase_ticks + 20'h00001;
		end
	end

	// sequencer; a stop request outranks every fault action
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			seq_state        <= seq_pkg::ST_OFF;
			power_enable     <= 1'b0;
			ref_level        <= 10'h000;
			restart_attempts <= 3'h0;
			rise_time        <= 16'h0001;
			fall_acc         <= 32'h0;
		end
		else
		begin
			case (seq_state)
				seq_pkg::ST_OFF:
				begin
					restart_attempts <= 3'h0;
					if (run_request)
					begin
						seq_state    <= seq_pkg::ST_RAMP;
						power_enable <= 1'b1;
						ref_level    <= `REF_FULL;
					end
				end
				seq_pkg::ST_RAMP, seq_pkg::ST_ON, seq_pkg::ST_FAULT_DLY:
				begin
					if (!run_request)
						seq_state <= seq_pkg::ST_OFF_DELAY;
					else if (go_shut)
					begin
						power_enable <= 1'b0;
						ref_level    <= 10'h000;
						seq_state    <= to_hiccup ? seq_pkg::ST_HICCUP : seq_pkg::ST_LATCHED;
						if (to_hiccup && retry != `RETRY_FOREVER)
							restart_attempts <= restart_attempts + 3'h1;
					end
					else if (fault_event && resp == seq_pkg::RESP_DELAYED)
						seq_state <= seq_pkg::ST_FAULT_DLY;
					else if (seq_state == seq_pkg::ST_FAULT_DLY && delay_done)
						seq_state <= seq_pkg::ST_ON;
					else if (seq_state == seq_pkg::ST_RAMP && in_regulation_band
						&& !phase_restart)
					begin
						// ignore-mode faults fall through here and keep running
						seq_state        <= seq_pkg::ST_ON;
						restart_attempts <= 3'h0;
						rise_time        <= (phase_ticks == 20'h0) ? 16'h0001
							: (phase_ticks > 20'h0FFFF) ? 16'hFFFF
							: phase_ticks[15:0];
					end
				end
				seq_pkg::ST_OFF_DELAY:
				begin
					// one cycle to register the stop, well inside the 50 us allowance
					fall_acc <= 32'h0;
					if (!phase_restart && phase_ticks >= 20'(off_now.q))
						seq_state <= seq_pkg::ST_FALL;
				end
				seq_pkg::ST_FALL:
				begin
					// error accumulator: full scale over fall_cycles steps, exact duration
					if (ref_level == 10'h000)
					begin
						seq_state    <= seq_pkg::ST_OFF;
						power_enable <= 1'b0;
					end
					else if (fall_acc + 32'(`REF_FULL) >= fall_cycles)
					begin
						fall_acc  <= fall_acc + 32'(`REF_FULL) - fall_cycles;
						ref_level <= ref_level - 10'h001;
					end
					else
						fall_acc <= fall_acc + 32'(`REF_FULL);
				end
				seq_pkg::ST_HICCUP:
				begin
					if (!run_request)
					begin
						seq_state        <= seq_pkg::ST_OFF;
						restart_attempts <= 3'h0;
					end
					else if (!phase_restart && phase_ticks >= 20'(hiccup_ticks))
					begin
						seq_state    <= seq_pkg::ST_RAMP;
						power_enable <= 1'b1;
						ref_level    <= `REF_FULL;
					end
				end
				seq_pkg::ST_LATCHED:
				begin
					if (!run_request)
					begin
						seq_state        <= seq_pkg::ST_OFF;
						restart_attempts <= 3'h0;
					end
				end
				default:
				begin
					seq_state    <= seq_pkg::ST_OFF;
					power_enable <= 1'b0;
				end
			endcase
		end
	end

	// sticky status; a set in the clearing cycle wins
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			status_none_of_above    <= 1'b0;
			status_word_vout        <= 1'b0;
			status_vout_ton_max     <= 1'b0;
			status_cml_invalid_data <= 1'b0;
			status_cml_invalid_cmd  <= 1'b0;
			alert_n                 <= 1'b1;
		end
		else
		begin
			status_none_of_above    <= (status_none_of_above && !clear_faults) || fault_event;
			status_word_vout        <= (status_word_vout && !clear_faults) || fault_event;
			status_vout_ton_max     <= (status_vout_ton_max && !clear_faults) || fault_event;
			status_cml_invalid_data <= (status_cml_invalid_data && !clear_faults) || bad_data;
			status_cml_invalid_cmd  <= (status_cml_invalid_cmd && !clear_faults)
				|| (cmd_valid && !known_cmd);
			// alert follows the flags one cycle later
			alert_n <= !(status_none_of_above || status_word_vout || status_vout_ton_max
				|| status_cml_invalid_data || status_cml_invalid_cmd);
		end
	end

	// checks
	property p_fault_flags;
		@(posedge clock) disable iff (!rst_n)
		fault_event |=> status_vout_ton_max && status_word_vout && status_none_of_above;
	endproperty
	a_fault_flags: assert property (p_fault_flags) else $error("fault flags not set");
	property p_fault_alert;
		@(posedge clock) disable iff (!rst_n)
		fault_event |-> ##2 !alert_n;
	endproperty
	a_fault_alert: assert property (p_fault_alert) else $error("no alert after fault");
	property p_ignore;
		@(posedge clock) disable iff (!rst_n)
		fault_event && resp == seq_pkg::RESP_IGNORE && run_request && seq_state == seq_pkg::ST_ON
		|=> power_enable && seq_state == seq_pkg::ST_ON;
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored fault interrupted");
	property p_delayed;
		@(posedge clock) disable iff (!rst_n)
		fault_event && resp == seq_pkg::RESP_DELAYED && run_request
		|=> power_enable && seq_state == seq_pkg::ST_FAULT_DLY;
	endproperty
	a_delayed: assert property (p_delayed) else $error("delayed response stopped early");
	property p_immediate;
		@(posedge clock) disable iff (!rst_n)
		fault_event && resp == seq_pkg::RESP_IMMEDIATE && run_request |=> !power_enable;
	endproperty
	a_immediate: assert property (p_immediate) else $error("no immediate shutdown");
	property p_bad_policy;
		@(posedge clock) disable iff (!rst_n)
		wr_policy && cmd.data[7:6] == 2'h3 |=> $stable(policy) && status_cml_invalid_data;
	endproperty
	a_bad_policy: assert property (p_bad_policy) else $error("bad policy accepted");
	property p_latch_off;
		@(posedge clock) disable iff (!rst_n)
		go_shut && run_request && retry == 3'h0 |=> seq_state == seq_pkg::ST_LATCHED;
	endproperty
	a_latch_off: assert property (p_latch_off) else $error("retry zero did not latch");
	property p_retry_bound;
		@(posedge clock) disable iff (!rst_n)
		retry != `RETRY_FOREVER && $changed(restart_attempts) && restart_attempts != 3'h0
		|-> restart_attempts <= retry;
	endproperty
	a_retry_bound: assert property (p_retry_bound) else $error("too many restarts");
	property p_range;
		@(posedge clock) disable iff (!rst_n)
		(wr_off && !off_wr.ok) || (wr_fall && !fall_wr.ok)
		|=> status_cml_invalid_data ##1 !alert_n;
	endproperty
	a_range: assert property (p_range) else $error("range error not flagged");
	property p_fall_end;
		@(posedge clock) disable iff (!rst_n)
		seq_state == seq_pkg::ST_FALL && ref_level == 10'h000
		|=> seq_state == seq_pkg::ST_OFF && !power_enable;
	endproperty
	a_fall_end: assert property (p_fall_end) else $error("soft-off did not end at zero");
	property p_fall_min;
		@(posedge clock) disable iff (!rst_n)
		fall_cycles >= 32'(TICK_CYCLES) * 32'd2;
	endproperty
	a_fall_min: assert property (p_fall_min) else $error("fall time under minimum");
	property p_success_clears;
		@(posedge clock) disable iff (!rst_n)
		seq_state == seq_pkg::ST_ON && $past(seq_state) == seq_pkg::ST_RAMP
		|-> restart_attempts == 3'h0;
	endproperty
	a_success_clears: assert property (p_success_clears) else $error("attempts kept");
	c_hiccup: cover property (@(posedge clock) seq_state == seq_pkg::ST_HICCUP);
	c_soft_off: cover property (@(posedge clock) seq_state == seq_pkg::ST_FALL);
	c_fault_delay: cover property (@(posedge clock) seq_state == seq_pkg::ST_FAULT_DLY);
endmodule : startup_fault_and_soft_off_control

// file: hdl/tick_divider.sv
// Purpose: quarter millisecond tick, restartable so phases start aligned
// Assumes: one clock domain
// Notes:   tick is a one cycle pulse
`timescale 1ns/100ps
module tick_divider #(
	parameter int CYCLES = 12500
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// control
	input  wire logic restart,
	output logic      tick
);
	localparam int W = $clog2(CYCLES);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	logic [W-1:0] count;

	// a divider of one could never drop tick between two pulses
	if (CYCLES < 2)
	begin : g_cycles_check
		$error("tick_divider needs at least two cycles");
	end

	// restart realigns the phase, otherwise a timed phase could lose a tick
	always_ff @(posedge clock)
	begin
		if (!rst_n || restart)
		begin
			count <= '0;
			tick  <= 1'b0;
		end
		else
		begin
			tick  <= (count == LAST);
			count <= (count == LAST) ? '0 : count + 1'b1;
		end
	end
endmodule : tick_divider

// file: sim/pmbus_host_model.sv
// Purpose: host side of the command port, issuing byte and word commands
// Assumes: one command at a time, driven on the falling edge
// Notes:   a released payload shows the inverse of its last value
`timescale 1ns/100ps
module pmbus_host_model (
	// clock
	input  wire logic        clock,
	// command port
	output logic             cmd_valid,
	output seq_pkg::cmd_t    cmd,
	input  wire logic        rsp_valid,
	input  wire logic [15:0] rsp_data
);
	// idle until the first command
	initial
	begin
		cmd_valid = 1'b0;
		cmd       = '0;
	end

	// one command, held over exactly one taking edge
	task automatic send(input logic wr, input logic wd, input logic [7:0] code,
		input logic [15:0] data);
	begin
		@(negedge clock);
		cmd       = '{wr, wd, code, data};
		cmd_valid = 1'b1;
		@(negedge clock);
		cmd_valid = 1'b0;
		cmd       = ~cmd; // stale payload must not look valid
	end
	endtask : send

	// read: the answer stands one cycle, so look in each of the next two
	task automatic read(input logic wd, input logic [7:0] code,
		output logic [15:0] data, output logic got);
	begin
		send(1'b0, wd, code, 16'h0000);
		got  = 1'b0;
		data = 16'hXXXX;
		repeat (2)
		begin
			if (!got && rsp_valid === 1'b1)
			begin
				got  = 1'b1;
				data = rsp_data;
			end
			if (!got)
				@(negedge clock);
		end
	end
	endtask : read
endmodule : pmbus_host_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for fault policy and soft-off sequencing
// Assumes: short tick of 512 cycles stands for a quarter millisecond
// Notes:   inputs change on the falling edge only
`timescale 1ns/100ps
`include "seq_defines.svh"
module tb_top;
	localparam int TC = 512;
	logic              clock = 1'b0, rst_n = 1'b0, cmd_valid, rsp_valid;
	seq_pkg::cmd_t     cmd;
	logic [15:0]       rsp_data, vout_sample = 16'h0000, vout_target = 16'h03E8;
	logic              run_request = 1'b0, ton_max_expire = 1'b0;
	logic              in_regulation_band = 1'b0, clear_faults = 1'b0;
	logic              s_none, s_word, s_ton, s_data, s_cmd, alert_n, power_enable;
	logic [9:0]        ref_level;
	seq_pkg::state_t   seq_state;
	logic [2:0]        restart_attempts;
	int                err_total = 0, samples_checked = 0;
	// write table: code, data, refused, value read back
	logic [7:0]        t_code [6] = '{8'h64, 8'h64, 8'h65, 8'h65, 8'h63, 8'h63};
	logic [15:0]       t_data [6] = '{16'hF900, 16'hF8FF, 16'hF080, 16'hF07F, 16'h00C0, 16'h003A};
	logic              t_bad [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic [15:0]       t_exp [6] = '{16'hF800, 16'hF8FF, 16'hF004, 16'hF07F, 16'h0080, 16'h003A};

	always #10 clock = ~clock;

	startup_fault_and_soft_off_control #(.TICK_CYCLES(TC)) u_startup_fault_and_soft_off_control (
		.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd(cmd),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .run_request(run_request),
		.ton_max_expire(ton_max_expire), .in_regulation_band(in_regulation_band),
		.vout_sample(vout_sample), .vout_target(vout_target), .clear_faults(clear_faults),
		.status_none_of_above(s_none), .status_word_vout(s_word),
		.status_vout_ton_max(s_ton), .status_cml_invalid_data(s_data),
		.status_cml_invalid_cmd(s_cmd), .alert_n(alert_n), .power_enable(power_enable),
		.ref_level(ref_level), .seq_state(seq_state), .restart_attempts(restart_attempts));

	pmbus_host_model u_pmbus_host_model (.clock(clock), .cmd_valid(cmd_valid),
		.cmd(cmd), .rsp_valid(rsp_valid), .rsp_data(rsp_data));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask : check

	task automatic close_out();
	begin
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask : close_out

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
	begin
		u_pmbus_host_model.send(1'b1, code != `CMD_POLICY, code, data);
	end
	endtask : wr

	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		logic [15:0] d;
		logic        got;
	begin
		u_pmbus_host_model.read(code != `CMD_POLICY, code, d, got);
		check("read answer", {15'h0000, got}, 16'h0001);
		check("read data", d, exp);
	end
	endtask : rd

	// bounded wait on the sequencer state
	task automatic wait_st(input seq_pkg::state_t s, input int lim);
		int n;
	begin
		n = 0;
		while (seq_state !== s && n < lim)
		begin
			@(negedge clock);
			n++;
		end
		check("state", {13'h0000, seq_state}, {13'h0000, s});
	end
	endtask : wait_st

	task automatic pulse(ref logic sig);
	begin
		@(negedge clock);
		sig = 1'b1;
		@(negedge clock);
		sig = 1'b0;
		repeat (3) @(negedge clock); // status and alert land within two edges
	end
	endtask : pulse

	task automatic start();
	begin
		run_request        = 1'b1;
		in_regulation_band = 1'b1;
		wait_st(seq_pkg::ST_ON, 200);
	end
	endtask : start

	task automatic stop();
	begin
		run_request = 1'b0;
		wait_st(seq_pkg::ST_OFF, 20000);
		check("attempts cleared", {13'h0000, restart_attempts}, 16'h0000);
	end
	endtask : stop

	// stop while on: delay with energy, then a fall of fixed length
	task automatic soft_off(input logic [15:0] dw, input logic [15:0] fw);
		int n, ed, ef;
	begin
		wr(`CMD_OFF_DELAY, dw);
		wr(`CMD_FALL_TIME, fw);
		ed = int'(dw[10:0]) * TC;
		ef = (fw[10:0] < 11'h002 ? 2 : int'(fw[10:0])) * TC; // short falls run as 0.5 ms
		start();
		run_request = 1'b0;
		n = 0;
		while (seq_state !== seq_pkg::ST_FALL && n < 40000)
		begin
			@(negedge clock);
			n++;
		end
		check("delay span", {15'h0000, n >= ed && n <= ed + 8}, 16'h0001);
		check("energy after delay", {15'h0000, power_enable}, 16'h0001);
		n = 0;
		while (seq_state === seq_pkg::ST_FALL && n < 40000)
		begin
			if (n == ef / 2)
				check("ref mid", {15'h0000, ref_level > 10'h180 && ref_level < 10'h280}, 16'h0001);
			@(negedge clock);
			n++;
		end
		check("fall span", {15'h0000, n >= ef - 4 && n <= ef + 4}, 16'h0001);
		wait_st(seq_pkg::ST_OFF, 8);
		check("energy off", {15'h0000, power_enable}, 16'h0000);
	end
	endtask : soft_off

	// fault in on state, then look at status and alert
	task automatic fault_on(input logic [7:0] pol, input logic [15:0] vs, input logic hit);
	begin
		pulse(clear_faults);
		wr(`CMD_POLICY, {8'h00, pol});
		start();
		vout_sample = vs;
		pulse(ton_max_expire);
		check("summary bit", {15'h0000, s_none}, {15'h0000, hit});
		check("word vout bit", {15'h0000, s_word}, {15'h0000, hit});
		check("timeout bit", {15'h0000, s_ton}, {15'h0000, hit});
		check("alert", {15'h0000, alert_n}, {15'h0000, !hit});
		vout_sample = 16'h0000;
	end
	endtask : fault_on

	initial
	begin
		#600_000;
		err_total++;
		close_out();
	end

	initial
	begin
		repeat (2) @(negedge clock);
		rst_n = 1'b1;
		rd(`CMD_POLICY, 16'h0080);
		rd(`CMD_OFF_DELAY, 16'hF800);
		rd(`CMD_FALL_TIME, 16'hF004);
		$display("test reset finished");
		for (int i = 0; i < 6; i++)
		begin
			pulse(clear_faults);
			wr(t_code[i], t_data[i]);
			repeat (2) @(negedge clock);
			check("invalid data", {15'h0000, s_data}, {15'h0000, t_bad[i]});
			check("alert", {15'h0000, alert_n}, {15'h0000, !t_bad[i]});
			check("invalid cmd", {15'h0000, s_cmd}, 16'h0000);
			rd(t_code[i], t_exp[i]);
		end
		// policy sent as a word is the wrong size and must be refused
		pulse(clear_faults);
		u_pmbus_host_model.send(1'b1, 1'b1, `CMD_POLICY, 16'h0000);
		repeat (2) @(negedge clock);
		check("invalid cmd", {15'h0000, s_cmd}, 16'h0001);
		check("alert", {15'h0000, alert_n}, 16'h0000);
		rd(`CMD_POLICY, 16'h003A);
		$display("test writes finished");
		soft_off(16'hF000, 16'hF002);
		soft_off(16'hF004, 16'hF001);
		soft_off(16'hF000, 16'hF004);
		$display("test soft off finished");
		fault_on(8'h80, 16'h0384, 1'b0);
		check("still on", {13'h0000, seq_state}, {13'h0000, seq_pkg::ST_ON});
		fault_on(8'h00, 16'h0000, 1'b1);
		check("ignored", {15'h0000, power_enable}, 16'h0001);
		fault_on(8'h80, 16'h0000, 1'b1);
		check("shut at once", {15'h0000, power_enable}, 16'h0000);
		wait_st(seq_pkg::ST_LATCHED, 4);
		stop();
		fault_on(8'h41, 16'h0000, 1'b1);
		vout_sample = 16'h03E8; // fault gone before the delay ends
		wait_st(seq_pkg::ST_ON, 4 * TC + 100);
		check("recovered", {15'h0000, power_enable}, 16'h0001);
		fault_on(8'h42, 16'h0000, 1'b1);
		repeat (8 * TC - 100) @(negedge clock);
		check("delay running", {15'h0000, power_enable}, 16'h0001);
		wait_st(seq_pkg::ST_LATCHED, 200);
		stop();
		$display("test responses finished");
		fault_on(8'h88, 16'h0000, 1'b1);
		check("one attempt", {13'h0000, restart_attempts}, 16'h0001);
		in_regulation_band = 1'b0;
		wait_st(seq_pkg::ST_RAMP, 3 * TC);
		pulse(ton_max_expire);
		wait_st(seq_pkg::ST_LATCHED, 4);
		stop();
		fault_on(8'hB8, 16'h0000, 1'b1);
		in_regulation_band = 1'b0;
		wait_st(seq_pkg::ST_RAMP, 3 * TC);
		pulse(ton_max_expire);
		wait_st(seq_pkg::ST_HICCUP, 4);
		wait_st(seq_pkg::ST_RAMP, 3 * TC);
		in_regulation_band = 1'b1;
		wait_st(seq_pkg::ST_ON, 8);
		stop();
		$display("test retries finished");
		close_out();
	end
endmodule : tb_top
